// file: psbe_pkg.sv
// Purpose: Shared constants for the pixel split and blanking encoder.
// Assumes: Seven serial bits per lane per pixel clock period, MSB first.
// Notes:   Patterns are written as 7-bit words, bit 6 leaves the lane first.
`default_nettype none
package psbe_pkg;
  localparam int LANE_BITS = 7;
  localparam int NUM_LANES = 8;
  localparam int NUM_WORDS = 9;
  localparam logic [2:0] BIT_LAST = 3'h6;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  // Clock lane words in balanced mode for data enable high and low.
  localparam logic [6:0] CLK_HI_A = 7'h78;
  localparam logic [6:0] CLK_HI_B = 7'h70;
  localparam logic [6:0] CLK_LO_A = 7'h7C;
  localparam logic [6:0] CLK_LO_B = 7'h60;
  // Control words sent during blanking for a high and a low level.
  localparam logic [6:0] CTL_HI_A = 7'h60;
  localparam logic [6:0] CTL_HI_B = 7'h7C;
  localparam logic [6:0] CTL_LO_A = 7'h70;
  localparam logic [6:0] CTL_LO_B = 7'h78;
  // Clock lane word in the non-balanced mode.
  localparam logic [6:0] CLK_LEGACY = 7'h63;
  localparam logic [6:0] WORD_IDLE = 7'h00;
  localparam logic [23:0] PIXEL_RESET = 24'h00_0000;
  localparam logic [1:0] CTL_RESET = 2'h0;
  typedef logic [3:0][6:0] psbe_group_t;
  typedef logic [8:0][6:0] psbe_bank_t;
endpackage
`default_nettype wire

// file: psbe_lane_serializer.sv
// Purpose: Shifts the nine lane words out on the link clock.
// Assumes: Words arrive over a toggle request with a matching acknowledge.
// Notes:   When no new word is waiting, the last word is repeated.
`timescale 1ns/1ps
`default_nettype none
module psbe_lane_serializer (
  // Link clock and reset from the system domain.
  input  wire logic              linkClk,
  input  wire logic              rst,
  // Word bank handshake from the system domain.
  input  wire psbe_pkg::psbe_bank_t bank,
  input  wire logic              bankReq,
  output logic                   bankAck,
  // Serial lanes.
  output logic [8:0]             serialOut
);
  import psbe_pkg::*;

  logic [1:0]   rstSync;
  logic [1:0]   reqSync;
  logic [2:0]   bitCnt;
  logic [2:0]   next_bitCnt;
  psbe_bank_t   shifter;
  psbe_bank_t   next_shifter;
  logic         next_bankAck;
  logic         linkRst;

  assign linkRst = rstSync[1];

  // Reset and request pass two flip-flops into the link domain.
  always_ff @(posedge linkClk) begin
    rstSync <= {rstSync[0], rst};
    reqSync <= {reqSync[0], bankReq};
  end

  // Next shift state: load at a frame boundary if a new bank waits, else rotate left.
  always_comb begin
    next_bitCnt = (bitCnt == BIT_LAST) ? BIT_FIRST : bitCnt + 3'h1;
    next_bankAck = bankAck;
    next_shifter = shifter;
    for (int i = 0; i < NUM_WORDS; i++) begin
      next_shifter[i] = {shifter[i][5:0], shifter[i][6]};
    end
    if (bitCnt == BIT_LAST && reqSync[1] != bankAck) begin
      next_shifter = bank;
      next_bankAck = reqSync[1];
    end
  end

  // Shift registers hold the frame; the top bit goes out first.
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      bitCnt <= BIT_LAST;
      shifter <= '0;
      bankAck <= 1'b0;
    end else begin
      bitCnt <= next_bitCnt;
      shifter <= next_shifter;
      bankAck <= next_bankAck;
    end
  end

  // Serial bits come straight from the shifter tops, MSB first.
  generate
    for (genvar g = 0; g < NUM_WORDS; g++) begin : gLane
      assign serialOut[g] = shifter[g][6];
    end
  endgenerate
endmodule // psbe_lane_serializer
`default_nettype wire

// file: psbe_pixel_encoder.sv
// Purpose: Formats pixels and blanking controls into lane words.
// Assumes: clk_sys is the pixel clock; pixel and sync inputs are on it.
// Notes:   The balancing inversion itself is not done; data flags read 0.
// Notes on behaviour
// - Odd pixel lower group, even pixel upper.
// - Pairing restarts on data enable rising.
// - Conversion works with balance on or off.
// - Single mode disables upper lanes, second clock.
// - Dual mode drives both link clock outputs.
// - Balanced mode clock lane words follow data enable level.
// - Syncs and user controls on lanes 0,1,4,5.
// - Polarity low swaps high and low patterns.
// - Clock rising edge fixed, falling alternates.
// - Legacy mode sends redundant copies in spares.
// - Balance flag zero during blanking controls.
// - Control words always sent uninverted.
// - User controls sampled while vsync low, held.
// - Legacy mode sends plain bits, no encoding.
`timescale 1ns/1ps
`default_nettype none
module psbe_pixel_encoder (
  // Clocks and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        linkClk,
  // Pixel inputs; in conversion mode only pixelLower is used.
  input  wire logic [23:0] pixelLower,
  input  wire logic [23:0] pixelUpper,
  input  wire logic        dataEnable,
  input  wire logic        hsync,
  input  wire logic        vsync,
  input  wire logic        userControlE,
  input  wire logic        userControlF,
  // Configuration pins.
  input  wire logic        dualMode,
  input  wire logic        convertMode,
  input  wire logic        balanceEnable,
  input  wire logic        enablePolaritySelect,
  // Serial link outputs.
  output logic [7:0]       dataLane,
  output logic             linkClockLane,
  output logic             secondLinkClock,
  // Status.
  output logic             upperLanesEnabled,
  output logic [1:0]       heldUserControl
);
  import psbe_pkg::*;

  logic [3:0]  cfgMeta;
  logic [3:0]  cfgSync;
  logic [1:0]  ackSync;
  logic [23:0] hold;
  logic [23:0] next_hold;
  logic        phase;
  logic        next_phase;
  logic        dePrev;
  logic        vsPrev;
  logic [1:0]  next_heldUserControl;
  logic        alt;
  logic        next_alt;
  psbe_bank_t  bank;
  psbe_bank_t  next_bank;
  logic        req;
  logic        next_req;
  logic        next_upper;
  logic        bankAck;
  logic [8:0]  serialOut;
  logic        curPhase;
  logic        emit;
  logic        dual;
  logic        conv;
  logic        balance_enable;
  logic        pol;
  logic [23:0] lowPix;
  logic [23:0] upPix;
  logic        deActive;
  logic [1:0]  upSync;

  assign dual = cfgSync[0];
  assign conv = cfgSync[1];
  assign balance_enable = cfgSync[2];
  assign pol = cfgSync[3];
  // Data enable as the polarity select sees it; a low select makes it active low.
  assign deActive = dataEnable ~^ pol;

  // Moves colour bits 0,1 to positions 6,7 and bits 2..7 to 0..5.
  function automatic logic [23:0] reorder(input logic [23:0] p);
    reorder = {p[17:16], p[23:18], p[9:8], p[15:10], p[1:0], p[7:2]};
  endfunction

  // Picks a control word; polarity low swaps the two levels.
  function automatic logic [6:0] ctlWord(input logic lvl, input logic a, input logic pl);
    logic eff;
    eff = lvl ^ ~pl;
    ctlWord = eff ? (a ? CTL_HI_B : CTL_HI_A) : (a ? CTL_LO_B : CTL_LO_A);
  endfunction

  // Picks a clock lane word from data enable level.
  function automatic logic [6:0] clkWord(input logic lvl, input logic a, input logic pl);
    logic eff;
    eff = lvl ^ ~pl;
    clkWord = eff ? (a ? CLK_HI_B : CLK_HI_A) : (a ? CLK_LO_B : CLK_LO_A);
  endfunction

  // Builds four lane words for one group.
  function automatic psbe_group_t laneGroup(input logic [23:0] pix, input logic b,
                                            input logic blank, input logic [6:0] c0,
                                            input logic [6:0] c1, input logic [3:0] ex);
    logic [23:0] r;
    r = reorder(pix);
    for (int i = 0; i < 4; i++) begin
      if (!b) begin
        laneGroup[i] = {r[6*i +: 6], ex[i]};
      end else if (blank) begin
        laneGroup[i] = (i == 0) ? c0 : (i == 1) ? c1 : WORD_IDLE;
      end else begin
        laneGroup[i] = {1'b0, r[6*i +: 6]};
      end
    end
  endfunction

  // Configuration pins pass two flip-flops; acknowledge is synchronised.
  always_ff @(posedge clk_sys) begin
    cfgMeta <= {enablePolaritySelect, balanceEnable, convertMode, dualMode};
    cfgSync <= cfgMeta;
    ackSync <= {ackSync[0], bankAck};
  end

  // Upper-group enable crosses into the link domain over two flip-flops.
  always_ff @(posedge linkClk) begin
    upSync <= {upSync[0], upperLanesEnabled};
  end

  // Pairing phase; a data enable rise makes the current pixel odd.
  always_comb begin
    curPhase = (dataEnable && !dePrev) ? 1'b0 : phase;
    emit = conv ? curPhase : 1'b1;
    next_phase = conv ? ~curPhase : 1'b0;
    next_hold = (conv && !curPhase) ? pixelLower : hold;
    lowPix = conv ? hold : pixelLower;
    upPix = conv ? pixelLower : pixelUpper;
  end

  // User controls are sampled from one clock after vsync falls.
  // Until the first such cycle, lanes 4 and 5 carry the reset level.
  always_comb begin
    next_heldUserControl = heldUserControl;
    if (!vsync && !vsPrev) begin
      next_heldUserControl = {userControlE, userControlF};
    end
  end

  // Word bank is refreshed when a word is due and the last one was taken.
  // Words offered while an acknowledge is still owed are dropped, not queued.
  always_comb begin
    next_bank = bank;
    next_req = req;
    next_alt = alt;
    next_upper = dual || conv;
    if (emit && req == ackSync[1]) begin
      next_bank[3:0] = laneGroup(lowPix, balance_enable, !deActive,
                                 ctlWord(hsync, alt, pol), ctlWord(vsync, alt, pol),
                                 {dataEnable, vsync, hsync, dataEnable});
      next_bank[7:4] = laneGroup(upPix, balance_enable, !deActive,
                                 ctlWord(heldUserControl[0], alt, pol),
                                 ctlWord(heldUserControl[1], alt, pol),
                                 {dataEnable, vsync, hsync, dataEnable});
      next_bank[8] = balance_enable ? clkWord(dataEnable, alt, pol) : CLK_LEGACY;
      if (!next_upper) begin
        next_bank[7:4] = '0;
      end
      next_req = ~req;
      next_alt = ~alt;
    end
  end

  // Registers for pairing, sampling and the handshake bank.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hold <= PIXEL_RESET;
      phase <= 1'b0;
      dePrev <= 1'b0;
      vsPrev <= 1'b0;
      heldUserControl <= CTL_RESET;
      alt <= 1'b0;
      bank <= '0;
      req <= 1'b0;
      upperLanesEnabled <= 1'b0;
    end else begin
      hold <= next_hold;
      phase <= next_phase;
      dePrev <= dataEnable;
      vsPrev <= vsync;
      heldUserControl <= next_heldUserControl;
      alt <= next_alt;
      bank <= next_bank;
      req <= next_req;
      upperLanesEnabled <= next_upper;
    end
  end

  // Link-side shifter; it owns the bit counter and the acknowledge.
  psbe_lane_serializer uSerializer (
    .linkClk   (linkClk),
    .rst       (rst),
    .bank      (bank),
    .bankReq   (req),
    .bankAck   (bankAck),
    .serialOut (serialOut)
  );

  // Second clock is the clock lane gated by upper-group enable.
  // The gate comes from the link domain, so it only moves on a bit boundary.
  assign dataLane = serialOut[7:0];
  assign linkClockLane = serialOut[8];
  assign secondLinkClock = serialOut[8] & upSync[1];
endmodule // psbe_pixel_encoder
`default_nettype wire

// file: psbe_encoder_properties.sv
// Purpose: Port checks for the pixel split and blanking encoder.
// Assumes: Mode pins stay put for several clocks at a time.
// Notes:   Serial lane checks run on the bit clock.
`timescale 1ns/1ps
`default_nettype none
module psbe_encoder_properties (
  // Clocks and inputs.
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       linkClk,
  input wire logic       vsync,
  input wire logic       userControlE,
  input wire logic       userControlF,
  input wire logic       dualMode,
  input wire logic       convertMode,
  input wire logic       balanceEnable,
  // Outputs.
  input wire logic       linkClockLane,
  input wire logic       secondLinkClock,
  input wire logic       upperLanesEnabled,
  input wire logic [1:0] heldUserControl
);
  logic cfgUp;
  // Either wide mode asks for the upper group.
  assign cfgUp = dualMode | convertMode;
  property p_up_on; @(posedge clk_sys) disable iff (rst)
    cfgUp[*5] |=> upperLanesEnabled; endproperty
  a_up_on: assert property (p_up_on) else $error("upper lanes stay off");
  property p_up_off; @(posedge clk_sys) disable iff (rst)
    (!cfgUp)[*5] |=> !upperLanesEnabled; endproperty
  a_up_off: assert property (p_up_off) else $error("upper lanes stay on");
  property p_held_take; @(posedge clk_sys) disable iff (rst) !vsync && !$past(vsync)
    |=> heldUserControl == {$past(userControlE), $past(userControlF)}; endproperty
  a_held_take: assert property (p_held_take) else $error("user controls not taken");
  property p_held_keep; @(posedge clk_sys) disable iff (rst)
    vsync |=> $stable(heldUserControl); endproperty
  a_held_keep: assert property (p_held_keep) else $error("user controls not held");
  property p_second_link_clock_off; @(posedge linkClk) disable iff (rst)
    !upperLanesEnabled && !$past(upperLanesEnabled) && !$past(upperLanesEnabled, 2)
    |-> !secondLinkClock; endproperty
  a_second_link_clock_off: assert property (p_second_link_clock_off) else $error("second clock active");
  property p_second_link_clock_copy; @(posedge linkClk) disable iff (rst)
    upperLanesEnabled && $past(upperLanesEnabled) && $past(upperLanesEnabled, 2)
    |-> secondLinkClock == linkClockLane; endproperty
  a_second_link_clock_copy: assert property (p_second_link_clock_copy) else $error("second clock differs");
  property p_ck_ones; @(posedge linkClk) disable iff (rst)
    linkClockLane[*5] |=> !linkClockLane; endproperty
  a_ck_ones: assert property (p_ck_ones) else $error("clock lane high too long");
  property p_ck_rise; @(posedge linkClk) disable iff (rst)
    $rose(linkClockLane) && balanceEnable && $past(balanceEnable, 32)
    |-> ##7 $rose(linkClockLane); endproperty
  a_ck_rise: assert property (p_ck_rise) else $error("clock lane rise moved");
endmodule // psbe_encoder_properties
`default_nettype wire

// file: psbe_link_receiver.sv
// Purpose: Receiver model recovering lane words from the serial link.
// Assumes: Every balanced-mode clock lane word begins with a rising edge.
// Notes:   The clock lane word sits at index 8 of the bank.
`timescale 1ns/1ps
`default_nettype none
module psbe_link_receiver (
  // Serial side.
  input  wire logic                 linkClk,
  input  wire logic                 rst,
  input  wire logic [7:0]           dataLane,
  input  wire logic                 linkClockLane,
  // Recovered words.
  output var psbe_pkg::psbe_bank_t  bank,
  output var int                    words
);
  import psbe_pkg::*;
  psbe_bank_t sh;
  logic [8:0] bits;
  logic       prev;
  logic       rise;
  int         cnt;
  assign bits = {linkClockLane, dataLane};
  assign rise = linkClockLane & !prev;
  // Aligns on the clock rise and takes seven bits, first bit as MSB.
  always @(posedge linkClk) begin
    for (int k = 0; k < 9; k++)
      sh[k] <= {sh[k][5:0], bits[k]};
    cnt <= rise ? 1 : cnt + 1;
    prev <= linkClockLane;
    if (cnt == 6 && !rise) begin
      for (int k = 0; k < 9; k++)
        bank[k] <= {sh[k][5:0], bits[k]};
      words <= words + 1;
    end
    if (rst)
      words <= 0;
  end
endmodule // psbe_link_receiver
`default_nettype wire

// file: tb_psbe_pixel_encoder.sv
// Purpose: Self-checking bench for the pixel split and blanking encoder.
// Assumes: Balanced mode except in the legacy test, where the receiver model frames words off the word boundary.
// Notes:   Expected words come from the pattern sets and bit reorder.
`timescale 1ns/1ps
`default_nettype none
module tb_psbe_pixel_encoder;
  import psbe_pkg::*;
  logic clk_sys, rst, linkClk, dataEnable, hsync, vsync, userControlE, userControlF;
  logic dualMode, convertMode, balanceEnable, enablePolaritySelect;
  logic linkClockLane, secondLinkClock, upperLanesEnabled;
  logic [23:0] pixelLower, pixelUpper, pa, pb;
  logic [31:0] v;
  logic [7:0]  dataLane;
  logic [1:0]  heldUserControl, expHeld;
  logic [6:0]  w;
  logic [3:0]  ex;
  psbe_bank_t  bank;
  int          words, err_count, samples_checked, seed;
  psbe_pixel_encoder i_psbe_pixel_encoder (.clk_sys, .rst, .linkClk, .pixelLower,
    .pixelUpper, .dataEnable, .hsync, .vsync, .userControlE, .userControlF, .dualMode,
    .convertMode, .balanceEnable, .enablePolaritySelect, .dataLane, .linkClockLane,
    .secondLinkClock, .upperLanesEnabled, .heldUserControl);
  psbe_link_receiver i_psbe_link_receiver (.linkClk, .rst, .dataLane, .linkClockLane,
    .bank, .words);
  // Pixel clock and an unrelated serial bit clock.
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  initial begin
    linkClk = 0;
    #7;
    forever #24 linkClk = ~linkClk;
  end
  // The single stream alternates odd and even pixels while active.
  always @(posedge clk_sys)
    if (convertMode && dataEnable) pixelLower <= (pixelLower === pa) ? pb : pa;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [6:0] seen, input logic [6:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %0t word %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [6:0] alt(logic [6:0] w, logic [6:0] a, logic [6:0] b);
    return (w === a) ? a : b;
  endfunction
  function automatic logic [6:0] ctl(logic lev, logic [6:0] w);
    return (lev ^ !enablePolaritySelect) ? alt(w, CTL_HI_A, CTL_HI_B) : alt(w, CTL_LO_A, CTL_LO_B);
  endfunction
  function automatic logic [6:0] lw(logic [23:0] p, int i);
    logic [23:0] r;
    for (int c = 0; c < 3; c++)
      r[8*c +: 8] = {p[8*c+1], p[8*c], p[8*c+7 -: 6]};
    return {1'b0, r[6*i +: 6]};
  endfunction
  // Waits for six fresh words, enough to cover the handshake and one frame.
  task automatic settle;
    int n;
    n = words + 6;
    for (int i = 0; i < 600 && words < n; i++)
      @(posedge clk_sys);
    if (words < n) begin
      err_count++;
      $display("MISMATCH %0t receiver words timed out", $time);
      report_and_stop;
    end
  endtask
  task automatic data_check(input logic [23:0] pl, input logic [23:0] pu, input logic up);
    settle;
    check(bank[8], alt(bank[8], CLK_HI_A, CLK_HI_B));
    check({6'h0, upperLanesEnabled}, {6'h0, up});
    for (int i = 0; i < 4; i++) begin
      check(bank[i], lw(pl, i));
      check(bank[i+4], up ? lw(pu, i) : WORD_IDLE);
    end
    $display("active test done");
  endtask
  initial begin
    seed = 9760;
    {rst, dataEnable, hsync, userControlE, userControlF, convertMode} = 6'h3F;
    {vsync, dualMode, balanceEnable, enablePolaritySelect} = 4'hF;
    {pixelLower, pixelUpper, pa, pb, expHeld} = '0;
    {dataEnable, hsync, userControlE, userControlF, convertMode} = 5'h0;
    {err_count, samples_checked} = '0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    // Blanking with random hsync and user controls, vsync toggling, under both polarities.
    for (int t = 0; t < 4; t++) begin
      v = $random(seed);
      @(posedge clk_sys);
      enablePolaritySelect <= (t < 2);
      dataEnable <= (t >= 2);
      {hsync, vsync, userControlE, userControlF} <= {v[0], t[0], v[2:1]};
      if (!t[0])
        expHeld = v[2:1];
      settle;
      check(bank[8], alt(bank[8], CLK_LO_A, CLK_LO_B));
      check(bank[0], ctl(hsync, bank[0]));
      check(bank[1], ctl(vsync, bank[1]));
      check(bank[4], ctl(expHeld[0], bank[4]));
      check(bank[5], ctl(expHeld[1], bank[5]));
      check(bank[2] | bank[3] | bank[6] | bank[7], WORD_IDLE);
      check({5'h0, heldUserControl}, {5'h0, expHeld});
      $display("blanking test %0d done", t);
    end
    // Dual, single, then dual mode with random pixel words.
    for (int t = 0; t < 3; t++) begin
      v = $random(seed);
      @(posedge clk_sys);
      enablePolaritySelect <= 1'b1;
      dualMode <= (t != 1);
      dataEnable <= 1'b1;
      pixelLower <= v[23:0];
      pixelUpper <= ~v[23:0];
      data_check(v[23:0], ~v[23:0], t != 1);
    end
    // Conversion: even blanking, then pairing from the data enable rise.
    v = $random(seed);
    @(posedge clk_sys);
    {dualMode, convertMode, dataEnable} <= 3'b010;
    pa <= v[23:0];
    pb <= {v[11:0], v[31:20]};
    repeat (4) @(posedge clk_sys);
    dataEnable <= 1'b1;
    pixelLower <= pa;
    data_check(pa, pb, 1'b1);
    // Legacy mode with balance off, as on a short link: plain bits and spare copies.
    v = $random(seed);
    @(posedge clk_sys);
    convertMode <= 1'b0;
    @(posedge clk_sys);
    {dualMode, balanceEnable} <= 2'b10;
    pixelLower <= v[23:0];
    pixelUpper <= ~v[23:0];
    ex = {1'b1, vsync, hsync, 1'b1};
    settle;
    // The receiver frames on the clock rise, two bits early here, so words are turned back.
    for (int k = 0; k < 9; k++) begin
      w = lw((k < 4) ? v[23:0] : ~v[23:0], k % 4);
      w = (k == 8) ? CLK_LEGACY : {w[5:0], ex[k % 4]};
      check({bank[k][4:0], bank[k][6:5]}, w);
    end
    $display("legacy test done");
    report_and_stop;
  end
endmodule // tb_psbe_pixel_encoder
bind psbe_pixel_encoder psbe_encoder_properties i_psbe_encoder_properties (.clk_sys, .rst,
  .linkClk, .vsync, .userControlE, .userControlF, .dualMode, .convertMode, .balanceEnable,
  .linkClockLane,
  .secondLinkClock, .upperLanesEnabled, .heldUserControl);
`default_nettype wire
